// ---- logic/irq_flag_cfg.svh ----
/*
 constants for the bridge and dma interrupt flag block.
 assumes inclusion by bare name from the design files.
*/
`ifndef IRQ_FLAG_CFG_SVH
`define IRQ_FLAG_CFG_SVH
`define OFS_BRIDGE_FLAGS 12'h000
`define OFS_BRIDGE_ENABLES 12'h004
`define OFS_BRIDGE_CTRL_FIRST 12'h008
`define OFS_BRIDGE_CTRL_SECOND 12'h00c
`define OFS_DMA_FLAGS_FIRST 12'h010
`define OFS_DMA_ENABLES_FIRST 12'h014
`define OFS_DMA_FLAGS_SECOND 12'h018
`define OFS_DMA_ENABLES_SECOND 12'h01c
`define OFS_CAPCOMP_ROUTE 12'h020
`define OFS_SRC_SELECT 12'h024
`define OFS_IRQ_STATUS 12'h028
`define OFS_IRQ_MASK 12'h02c
`define BRIDGE_W 15
`define DMA1_W 8
`define DMA2_W 6
`define CAPCOMP_W 4
`define POS_PUMP_LOW1 0
`define POS_PUMP_LOW2 1
`define POS_PUMP_HIGH 2
`define POS_OC_BASE 3
`define POS_DS_BASE 9
`define POS_D2_SEQ 0
`define POS_D2_ESEQ 1
`define POS_D2_STX 2
`define POS_D2_SRX 3
`define POS_D2_TIMER 4
`define POS_D2_SIGMA 5
`define POS_SEL_CH9 0
`define POS_SEL_CH11 1
`define POS_SEL_CH12 2
`define RST_ZERO 32'h0000_0000
`define RST_ROUTE 8'he4
`endif

// ---- logic/irq_flag_pkg.sv ----
/*
 types for the bridge and dma interrupt flag block.
 assumes nothing beyond a systemverilog compiler.
*/
package irq_flag_pkg;
    typedef enum logic [1:0] {
        apb_idle,
        apb_access
    } apb_phase_e;
    typedef logic [1:0] node_sel_t;
endpackage

// ---- logic/sticky_flags.sv ----
/*
 bank of sticky level flags with per-bit enables and write-one clear.
 assumes events and clear strobes synchronous to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module sticky_flags #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] event_in,
    input wire logic [W-1:0] clear_in,
    input wire logic [W-1:0] enable_in,
    output logic [W-1:0] flags,
    output logic request
);
    logic [W-1:0] flags_ff;
    logic [W-1:0] nxt_flags;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // set wins over clear
            always_comb begin
                nxt_flags[i] = event_in[i] | (flags_ff[i] & ~clear_in[i]);
            end
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end
    assign flags = flags_ff;
    assign request = |(flags_ff & enable_in);
endmodule
`default_nettype wire

// ---- logic/capcomp_router.sv ----
/*
 steers four capture-compare interrupts onto four nodes.
 assumes a 2-bit node select per source.
*/
`timescale 1ns/1ns
`default_nettype none
module capcomp_router (
    input wire logic [3:0] src_irq,
    input wire logic [7:0] route_sel,
    output logic [3:0] node_irq
);
    function automatic logic [3:0] onehot(input logic [1:0] s);
        onehot = 4'h1 << s;
    endfunction
    always_comb begin
        node_irq = 4'h0;
        for (int k = 0; k < 4; k++) begin
            if (src_irq[k]) begin
                node_irq = node_irq | onehot(route_sel[2*k +: 2]);
            end
        end
    end
endmodule
`default_nettype wire

// ---- logic/bridge_dma_irq_flag_mux.sv ----
/*
 interrupt flag and enable aggregation for nodes 14 and 15 with apb
 registers. assumes single-cycle event pulses or levels on pclk.
*/
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "irq_flag_cfg.svh"
module bridge_dma_irq_flag_mux #(
    parameter bit HAS_SIGMA = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pump_low1_evt,
    input wire logic pump_low2_evt,
    input wire logic pump_high_evt,
    input wire logic [5:0] overcurrent_evt,
    input wire logic [5:0] drain_mon_evt,
    input wire logic [7:0] converter_ch_done,
    input wire logic capcomp_zero_match,
    input wire logic capcomp_period_match,
    input wire logic timer_unit_evt,
    input wire logic third_timer_evt,
    input wire logic sigma_delta_evt,
    input wire logic sequence_ready_evt,
    input wire logic exceptional_sequence_ready_evt,
    input wire logic serial_tx_ready_evt,
    input wire logic serial_rx_ready_evt,
    input wire logic [3:0] capcomp_irq,
    output logic node14_req,
    output logic node15_req,
    output logic [3:0] capcomp_node_req,
    output logic irq
);
    irq_flag_pkg::apb_phase_e phase_ff, nxt_phase;
    logic ready_ff, nxt_ready;
    logic [`BRIDGE_W-1:0] bridge_event_enables_ff, nxt_bridge_en;
    logic [`DMA1_W-1:0] dma_enables_first_ff, nxt_dma1_en;
    logic [`DMA2_W-1:0] dma_enables_second_ff, nxt_dma2_en;
    logic [7:0] capcomp_node_select_ff, nxt_route;
    logic [2:0] src_sel_ff, nxt_src_sel;
    logic [1:0] irq_status_ff, nxt_irq_status;
    logic [1:0] irq_mask_ff, nxt_irq_mask;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [`BRIDGE_W-1:0] bridge_event_flags, bridge_evt, bridge_clr;
    logic [`DMA1_W-1:0] dma_flags_first, dma1_evt, dma1_clr;
    logic [`DMA2_W-1:0] dma_flags_second, dma2_evt, dma2_clr;
    logic [5:0] drain_mon_state_ff, nxt_drain_state;
    logic bridge_req, dma1_req, dma2_req;
    logic wr_fire, rd_fire;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    assign wr_fire = psel & penable & pwrite & pready;
    // read data is captured in the first access cycle, shown in the second
    assign rd_fire = psel & penable & ~pwrite
        & (phase_ff == irq_flag_pkg::apb_access) & ~ready_ff;

    always_comb begin
        bridge_evt = {drain_mon_evt, overcurrent_evt, pump_high_evt,
            pump_low2_evt, pump_low1_evt};
        dma1_evt = converter_ch_done;
        // channel 9 and 11 alternative sources
        dma1_evt[5] = src_sel_ff[`POS_SEL_CH9] ? capcomp_zero_match
            : converter_ch_done[5];
        dma1_evt[7] = src_sel_ff[`POS_SEL_CH11] ? capcomp_period_match
            : converter_ch_done[7];
        dma2_evt = '0;
        dma2_evt[`POS_D2_SEQ] = sequence_ready_evt;
        dma2_evt[`POS_D2_ESEQ] = exceptional_sequence_ready_evt;
        dma2_evt[`POS_D2_STX] = serial_tx_ready_evt;
        dma2_evt[`POS_D2_SRX] = serial_rx_ready_evt;
        dma2_evt[`POS_D2_TIMER] = src_sel_ff[`POS_SEL_CH12] ? third_timer_evt
            : timer_unit_evt;
        dma2_evt[`POS_D2_SIGMA] = HAS_SIGMA & sigma_delta_evt;
        bridge_clr = '0;
        dma1_clr = '0;
        dma2_clr = '0;
        if (wr_fire && hit(paddr, `OFS_BRIDGE_FLAGS)) begin
            bridge_clr = pwdata[`BRIDGE_W-1:0];
        end
        if (wr_fire && hit(paddr, `OFS_DMA_FLAGS_FIRST)) begin
            dma1_clr = pwdata[`DMA1_W-1:0];
        end
        if (wr_fire && hit(paddr, `OFS_DMA_FLAGS_SECOND)) begin
            dma2_clr = pwdata[`DMA2_W-1:0];
        end
    end

    sticky_flags #(.W(`BRIDGE_W)) u_bridge (
        .pclk(pclk),
        .presetn(presetn),
        .event_in(bridge_evt),
        .clear_in(bridge_clr),
        .enable_in(bridge_event_enables_ff),
        .flags(bridge_event_flags),
        .request(bridge_req)
    );
    sticky_flags #(.W(`DMA1_W)) u_dma1 (
        .pclk(pclk),
        .presetn(presetn),
        .event_in(dma1_evt),
        .clear_in(dma1_clr),
        .enable_in(dma_enables_first_ff),
        .flags(dma_flags_first),
        .request(dma1_req)
    );
    sticky_flags #(.W(`DMA2_W)) u_dma2 (
        .pclk(pclk),
        .presetn(presetn),
        .event_in(dma2_evt),
        .clear_in(dma2_clr),
        .enable_in(dma_enables_second_ff),
        .flags(dma_flags_second),
        .request(dma2_req)
    );
    capcomp_router u_route (
        .src_irq(capcomp_irq),
        .route_sel(capcomp_node_select_ff),
        .node_irq(capcomp_node_req)
    );

    assign node14_req = bridge_req;
    assign node15_req = dma1_req | dma2_req;

    always_comb begin
        nxt_phase = phase_ff;
        nxt_ready = 1'b0;
        nxt_bridge_en = bridge_event_enables_ff;
        nxt_dma1_en = dma_enables_first_ff;
        nxt_dma2_en = dma_enables_second_ff;
        nxt_route = capcomp_node_select_ff;
        nxt_src_sel = src_sel_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_prdata = prdata_ff;
        // drain-source state mirrors flags for the control registers
        nxt_drain_state = bridge_event_flags[`POS_DS_BASE +: 6];
        // node events set status; set wins over write-one clear
        nxt_irq_status = irq_status_ff | {node15_req, node14_req};
        unique case (phase_ff)
            irq_flag_pkg::apb_idle: begin
                if (psel && !penable) begin
                    nxt_phase = irq_flag_pkg::apb_access;
                end
            end
            irq_flag_pkg::apb_access: begin
                nxt_ready = ~ready_ff;
                if (ready_ff) begin
                    nxt_phase = irq_flag_pkg::apb_idle;
                end
            end
        endcase
        if (wr_fire) begin
            unique case (paddr)
                `OFS_BRIDGE_ENABLES: nxt_bridge_en = pwdata[`BRIDGE_W-1:0];
                `OFS_DMA_ENABLES_FIRST: nxt_dma1_en = pwdata[`DMA1_W-1:0];
                `OFS_DMA_ENABLES_SECOND: begin
                    nxt_dma2_en = pwdata[`DMA2_W-1:0];
                    nxt_dma2_en[`POS_D2_SIGMA] = HAS_SIGMA
                        & pwdata[`POS_D2_SIGMA];
                end
                `OFS_CAPCOMP_ROUTE: nxt_route = pwdata[7:0];
                `OFS_SRC_SELECT: nxt_src_sel = pwdata[2:0];
                `OFS_IRQ_STATUS: begin
                    nxt_irq_status = (irq_status_ff & ~pwdata[1:0])
                        | {node15_req, node14_req};
                end
                `OFS_IRQ_MASK: nxt_irq_mask = pwdata[1:0];
                default: begin
                end
            endcase
        end
        if (rd_fire) begin
            unique case (paddr)
                `OFS_BRIDGE_FLAGS: nxt_prdata = 32'(bridge_event_flags);
                `OFS_BRIDGE_ENABLES: nxt_prdata = 32'(bridge_event_enables_ff);
                `OFS_BRIDGE_CTRL_FIRST: begin
                    nxt_prdata = 32'(drain_mon_state_ff[3:0]);
                end
                `OFS_BRIDGE_CTRL_SECOND: begin
                    nxt_prdata = 32'(drain_mon_state_ff[5:4]);
                end
                `OFS_DMA_FLAGS_FIRST: nxt_prdata = 32'(dma_flags_first);
                `OFS_DMA_ENABLES_FIRST: nxt_prdata = 32'(dma_enables_first_ff);
                `OFS_DMA_FLAGS_SECOND: nxt_prdata = 32'(dma_flags_second);
                `OFS_DMA_ENABLES_SECOND: begin
                    nxt_prdata = 32'(dma_enables_second_ff);
                end
                `OFS_CAPCOMP_ROUTE: nxt_prdata = 32'(capcomp_node_select_ff);
                `OFS_SRC_SELECT: nxt_prdata = 32'(src_sel_ff);
                `OFS_IRQ_STATUS: nxt_prdata = 32'(irq_status_ff);
                `OFS_IRQ_MASK: nxt_prdata = 32'(irq_mask_ff);
                default: nxt_prdata = `RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= irq_flag_pkg::apb_idle;
            ready_ff <= 1'b0;
            bridge_event_enables_ff <= '0;
            dma_enables_first_ff <= '0;
            dma_enables_second_ff <= '0;
            capcomp_node_select_ff <= `RST_ROUTE;
            src_sel_ff <= '0;
            irq_status_ff <= '0;
            irq_mask_ff <= '0;
            prdata_ff <= `RST_ZERO;
            drain_mon_state_ff <= '0;
        end else begin
            phase_ff <= nxt_phase;
            ready_ff <= nxt_ready;
            bridge_event_enables_ff <= nxt_bridge_en;
            dma_enables_first_ff <= nxt_dma1_en;
            dma_enables_second_ff <= nxt_dma2_en;
            capcomp_node_select_ff <= nxt_route;
            src_sel_ff <= nxt_src_sel;
            irq_status_ff <= nxt_irq_status;
            irq_mask_ff <= nxt_irq_mask;
            prdata_ff <= nxt_prdata;
            drain_mon_state_ff <= nxt_drain_state;
        end
    end

    // access phase always needs one extra cycle so read data is registered
    assign pready = (phase_ff == irq_flag_pkg::apb_access) & ready_ff;
    assign prdata = prdata_ff;
    assign pslverr = 1'b0;
    assign irq = |(irq_status_ff & irq_mask_ff);
endmodule
`default_nettype wire

// ---- tb/irq_flag_monitor.sv ----
/*
 port checker for the interrupt flag block.
 assumes the bind at the foot of this file.
*/
`timescale 1ns/1ns
`default_nettype none
module irq_flag_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pump_low1_evt,
    input wire logic pump_low2_evt,
    input wire logic pump_high_evt,
    input wire logic [5:0] overcurrent_evt,
    input wire logic [5:0] drain_mon_evt,
    input wire logic sequence_ready_evt,
    input wire logic exceptional_sequence_ready_evt,
    input wire logic serial_tx_ready_evt,
    input wire logic serial_rx_ready_evt,
    input wire logic [3:0] capcomp_irq,
    input wire logic node14_req,
    input wire logic node15_req,
    input wire logic [3:0] capcomp_node_req,
    input wire logic irq
);
    logic wr;
    logic [14:0] ev14;
    logic [3:0] ev2;
    logic route_wr_ff;
    logic [14:0] en14_ff;
    logic [3:0] en2_ff;
    logic [1:0] mask_ff;
    assign wr = psel && penable && pwrite && pready;
    assign ev14 = {drain_mon_evt, overcurrent_evt, pump_high_evt,
        pump_low2_evt, pump_low1_evt};
    assign ev2 = {serial_rx_ready_evt, serial_tx_ready_evt,
        exceptional_sequence_ready_evt, sequence_ready_evt};
    // shadows of the enable, mask and route writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_wr_ff <= 1'b0;
            en14_ff <= 15'h0;
            en2_ff <= 4'h0;
            mask_ff <= 2'h0;
        end else if (wr) begin
            if (paddr == 12'h020) route_wr_ff <= 1'b1;
            if (paddr == 12'h004) en14_ff <= pwdata[14:0];
            if (paddr == 12'h01c) en2_ff <= pwdata[3:0];
            if (paddr == 12'h02c) mask_ff <= pwdata[1:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait_ready;
        !pready ##1 pready;
    endsequence
    sequence s_bridge_evt;
        |(ev14 & en14_ff) && !wr;
    endsequence
    sequence s_dma_evt;
        |(ev2 & en2_ff) && !wr;
    endsequence
    a_access_ready: assert property (s_setup |=> s_wait_ready)
        else $error("no pready after setup");
    a_bridge_req: assert property (s_bridge_evt |=> node14_req)
        else $error("bridge event gave no request");
    a_dma_req: assert property (s_dma_evt |=> node15_req)
        else $error("dma event gave no request");
    a_req14_level: assert property (node14_req && !wr |=> node14_req)
        else $error("node14 request dropped alone");
    a_req15_level: assert property (node15_req && !wr |=> node15_req)
        else $error("node15 request dropped alone");
    a_irq_level: assert property (irq && !wr |=> irq)
        else $error("irq dropped alone");
    a_no_enable: assert property (en14_ff == 15'h0 |-> !node14_req)
        else $error("node14 request with no enable");
    a_mask_gate: assert property (mask_ff == 2'h0 |-> !irq)
        else $error("irq while masked");
    a_rdata_hold: assert property (!(wr || psel && penable) |=>
        $stable(prdata))
        else $error("prdata changed without read");
    a_route_reset: assert property (!route_wr_ff |->
        capcomp_node_req == capcomp_irq)
        else $error("default route not one to one");
endmodule
bind bridge_dma_irq_flag_mux irq_flag_monitor mon (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pump_low1_evt,
    .pump_low2_evt, .pump_high_evt, .overcurrent_evt, .drain_mon_evt,
    .sequence_ready_evt, .exceptional_sequence_ready_evt,
    .serial_tx_ready_evt, .serial_rx_ready_evt, .capcomp_irq, .node14_req,
    .node15_req, .capcomp_node_req, .irq);
`default_nettype wire

// ---- tb/core_model.sv ----
/*
 core side model: acknowledges node requests.
 assumes level requests on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic node14_req,
    input wire logic node15_req,
    output logic [1:0] ack
);
    // acknowledge never reaches the flags; software clears them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack <= 2'h0;
        end else begin
            ack <= {node15_req, node14_req} & ~ack;
        end
    end
endmodule
`default_nettype wire

// ---- tb/bridge_dma_irq_flag_mux_tb.sv ----
/*
 self-checking bench for the interrupt flag block.
 assumes the design, its checker bind and the core model.
*/
`timescale 1ns/1ns
`default_nettype none
module bridge_dma_irq_flag_mux_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic node14_req, node15_req, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata, evt;
    logic [3:0] capcomp_irq, capcomp_node_req;
    logic [1:0] ack;
    int fail_count = 0;
    int checked = 0;
    bridge_dma_irq_flag_mux DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pump_low1_evt(evt[0]), .pump_low2_evt(evt[1]),
        .pump_high_evt(evt[2]), .overcurrent_evt(evt[8:3]),
        .drain_mon_evt(evt[14:9]), .converter_ch_done(evt[22:15]),
        .capcomp_zero_match(evt[23]), .capcomp_period_match(evt[24]),
        .sequence_ready_evt(evt[25]),
        .exceptional_sequence_ready_evt(evt[26]),
        .serial_tx_ready_evt(evt[27]), .serial_rx_ready_evt(evt[28]),
        .timer_unit_evt(evt[29]), .sigma_delta_evt(evt[30]),
        .third_timer_evt(evt[31]), .capcomp_irq, .node14_req, .node15_req,
        .capcomp_node_req, .irq);
    core_model core (.pclk, .presetn, .node14_req, .node15_req, .ack);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic pulse(input logic [31:0] v);
        @(posedge pclk);
        evt <= v;
        @(posedge pclk);
        evt <= 32'h0;
        @(negedge pclk);
    endtask
    task automatic summarize();
        $display("checked %0d failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        summarize();
    end
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        evt = 32'h0;
        capcomp_irq = 4'h5;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h020, 32'he4);
        chk("route", 32'h5, capcomp_node_req);
        apb(1'b1, 12'h030, 32'hffff_ffff);
        rdc(12'h030, 32'h0);
        chk("slverr", 32'h0, pslverr);
        $display("test reset done");
        for (int i = 0; i < 15; i++) begin
            pulse(32'h1 << i);
            chk("node14 off", 32'h0, node14_req);
            rdc(12'h000, 32'h1 << i);
            if (i > 8) begin
                rdc(i < 13 ? 12'h008 : 12'h00c,
                    32'h1 << ((i - 9) % 4));
            end
            apb(1'b1, 12'h004, 32'h1 << i);
            chk("node14 on", 32'h1, node14_req);
            apb(1'b1, 12'h000, 32'h1 << i);
            chk("node14 clr", 32'h0, node14_req);
        end
        apb(1'b1, 12'h004, 32'h7fff);
        pulse(32'h4);
        chk("node14 all en", 32'h1, node14_req);
        apb(1'b1, 12'h000, 32'h4);
        chk("node14 all clr", 32'h0, node14_req);
        apb(1'b1, 12'h004, 32'h0);
        $display("test bridge done");
        apb(1'b1, 12'h014, 32'hff);
        for (int k = 0; k < 8; k++) begin
            pulse(32'h1 << (15 + k));
            rdc(12'h010, 32'h1 << k);
            chk("node15", 32'h1, node15_req);
            apb(1'b1, 12'h010, 32'h1 << k);
        end
        pulse(32'h3 << 23);
        rdc(12'h010, 32'h0);
        apb(1'b1, 12'h024, 32'h3);
        pulse(32'h3 << 23);
        rdc(12'h010, 32'ha0);
        apb(1'b1, 12'h010, 32'ha0);
        apb(1'b1, 12'h01c, 32'h3f);
        for (int k = 0; k < 6; k++) begin
            pulse(32'h1 << (25 + k));
            rdc(12'h018, 32'h1 << k);
            apb(1'b1, 12'h018, 32'h1 << k);
        end
        apb(1'b1, 12'h024, 32'h4);
        pulse(32'h8000_0000);
        rdc(12'h018, 32'h10);
        repeat (4) @(negedge pclk);
        chk("node15 held", 32'h1, node15_req);
        $display("test dma done");
        rdc(12'h028, 32'h3);
        chk("irq masked", 32'h0, irq);
        apb(1'b1, 12'h02c, 32'h2);
        chk("irq", 32'h1, irq);
        apb(1'b1, 12'h018, 32'h10);
        apb(1'b1, 12'h028, 32'h3);
        chk("irq clr", 32'h0, irq);
        apb(1'b1, 12'h020, 32'h1b);
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            capcomp_irq <= 4'h1 << k;
            @(negedge pclk);
            chk("route", 32'h8 >> k, capcomp_node_req);
        end
        $display("test irq and route done");
        summarize();
    end
endmodule
`default_nettype wire
